// ==== inc/gpint_consts.svh ====
// Offsets, reset values and field constants of the pin port with interrupts
// Notes on behaviour
// [RULE1] An enabled pin whose sampled level goes low to high raises an interrupt.
// [RULE2] An enabled pin whose sampled level goes high to low raises an interrupt.
// [RULE3] An enabled pin keeps its interrupt asserted while its sampled level is high.
// [RULE4] An enabled pin keeps its interrupt asserted while its sampled level is low.
// [RULE5] Per-pin output enable bit: set drives the output value, clear leaves pin undriven.
// [RULE6] Each pin owns the same bit position in every word of the port.
// [RULE7] Software reads back exactly the output enable word last written; a partial-strobe write merges only its selected byte lanes.
// [RULE8] Software reads the sampled level of every pin, whatever its output enable.
// [RULE9] Per-pin output value bit, driven while enabled and read back as stored.
`ifndef GPINT_CONSTS_SVH
`define GPINT_CONSTS_SVH

// Port geometry
`define GPINT_PINS 32
`define GPINT_ADDR_W 8
`define GPINT_STRB_W 4

// Register byte offsets
`define GPINT_OFF_INPUT 8'h00
`define GPINT_OFF_OUTPUT 8'h04
`define GPINT_OFF_OE 8'h08
`define GPINT_OFF_RISE_EN 8'h0C
`define GPINT_OFF_FALL_EN 8'h10
`define GPINT_OFF_HIGH_EN 8'h14
`define GPINT_OFF_LOW_EN 8'h18
`define GPINT_OFF_STATUS 8'h1C
`define GPINT_OFF_MASK 8'h20

// Reset values
`define GPINT_RST_ZERO 32'h00000000
`define GPINT_RST_MASK 32'hFFFFFFFF

// Bus responses
`define GPINT_RESP_OKAY 2'h0
`define GPINT_RESP_SLVERR 2'h2

`endif

// ==== inc/gpint_pkg.sv ====
// Types shared by the pin port with interrupts
package gpint_pkg;
    `include "gpint_consts.svh"

    typedef logic [`GPINT_PINS-1:0] gpint_word_t;
    typedef logic [`GPINT_ADDR_W-1:0] gpint_addr_t;
    typedef logic [`GPINT_STRB_W-1:0] gpint_strb_t;

    // Input synchroniser state
    typedef struct packed {
        gpint_word_t meta;
        gpint_word_t samp;
        gpint_word_t prev;
    } gpint_sync_t;

    // Whole state of the port and its bus slave, except the pin synchroniser
    typedef struct packed {
        logic aw_held;
        gpint_addr_t awaddr;
        logic w_held;
        logic [31:0] wdata;
        gpint_strb_t wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        gpint_word_t out;
        gpint_word_t oe;
        gpint_word_t rise_en;
        gpint_word_t fall_en;
        gpint_word_t high_en;
        gpint_word_t low_en;
        gpint_word_t status;
        gpint_word_t mask;
    } gpint_state_t;
endpackage

// ==== src/gpint_sync.sv ====
// Two-flop pin synchroniser with a one-cycle history for edge detection
`timescale 1ns/10ps
module gpint_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pin levels
    input wire gpint_pkg::gpint_word_t pin_raw,
    // Sampled level and its value one cycle earlier
    output gpint_pkg::gpint_word_t level,
    output gpint_pkg::gpint_word_t level_prev
);
    import gpint_pkg::*;

    gpint_sync_t s;
    gpint_sync_t next_s;

    // Meta stage feeds only the sample stage
    always_comb begin
        next_s = s;
        next_s.meta = pin_raw;
        next_s.samp = s.meta;
        next_s.prev = s.samp;
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flops
    assign level = s.samp;
    assign level_prev = s.prev;
endmodule

// ==== src/gpint_top.sv ====
// Pin port with per-pin edge and level interrupts behind an AXI4-Lite slave
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "gpint_consts.svh"
module gpint_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire gpint_pkg::gpint_addr_t s_axil_awaddr,
    // AXI4-Lite write data
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    input wire logic [31:0] s_axil_wdata,
    input wire gpint_pkg::gpint_strb_t s_axil_wstrb,
    // AXI4-Lite write response
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    output logic [1:0] s_axil_bresp,
    // AXI4-Lite read address
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    input wire gpint_pkg::gpint_addr_t s_axil_araddr,
    // AXI4-Lite read data
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    // Pins
    input wire gpint_pkg::gpint_word_t pin_in,
    output gpint_pkg::gpint_word_t pin_out,
    output gpint_pkg::gpint_word_t pin_oe,
    // Interrupt
    output logic irq
);
    import gpint_pkg::*;

    gpint_state_t s;
    gpint_state_t next_s;
    gpint_word_t level;
    gpint_word_t level_prev;
    gpint_word_t rise_hit;
    gpint_word_t fall_hit;
    gpint_word_t high_hit;
    gpint_word_t low_hit;
    gpint_word_t hits;
    gpint_addr_t wr_addr;
    gpint_addr_t rd_addr;
    logic wr_fire;
    logic rd_fire;

    // Word-aligned register address
    function automatic gpint_addr_t align_addr(input gpint_addr_t a);
        align_addr = {a[`GPINT_ADDR_W-1:2], 2'h0};
    endfunction

    // Map check shared by reads and writes
    function automatic logic is_mapped(input gpint_addr_t a);
        case (a)
            `GPINT_OFF_INPUT, `GPINT_OFF_OUTPUT, `GPINT_OFF_OE,
            `GPINT_OFF_RISE_EN, `GPINT_OFF_FALL_EN, `GPINT_OFF_HIGH_EN,
            `GPINT_OFF_LOW_EN, `GPINT_OFF_STATUS, `GPINT_OFF_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Byte-lane merge, so partial writes leave other pins alone
    function automatic gpint_word_t merge(input gpint_word_t old, input logic [31:0] data,
                                          input gpint_strb_t strb);
        merge = old;
        for (int i = 0; i < `GPINT_STRB_W; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    endfunction

    // Read multiplexer over the register map
    function automatic logic [31:0] read_word(input gpint_addr_t a, input gpint_state_t st,
                                              input gpint_word_t lvl);
        case (a)
            `GPINT_OFF_INPUT: read_word = lvl;
            `GPINT_OFF_OUTPUT: read_word = st.out;
            `GPINT_OFF_OE: read_word = st.oe;
            `GPINT_OFF_RISE_EN: read_word = st.rise_en;
            `GPINT_OFF_FALL_EN: read_word = st.fall_en;
            `GPINT_OFF_HIGH_EN: read_word = st.high_en;
            `GPINT_OFF_LOW_EN: read_word = st.low_en;
            `GPINT_OFF_STATUS: read_word = st.status;
            `GPINT_OFF_MASK: read_word = st.mask;
            default: read_word = `GPINT_RST_ZERO;
        endcase
    endfunction

    // Pins pass two flops before any logic sees them
    gpint_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_raw(pin_in),
        .level(level),
        .level_prev(level_prev)
    );

    // Per-pin interrupt causes, one bit position per pin
    assign rise_hit = s.rise_en & level & ~level_prev; // [RULE1] [RULE6]
    assign fall_hit = s.fall_en & ~level & level_prev; // [RULE2] [RULE6]
    assign high_hit = s.high_en & level; // [RULE3]
    assign low_hit = s.low_en & ~level; // [RULE4]
    assign hits = rise_hit | fall_hit | high_hit | low_hit;

    // Bus handshake terms; a write waits until its response has gone
    assign s_axil_awready = !s.aw_held && !s.bvalid;
    assign s_axil_wready = !s.w_held && !s.bvalid;
    assign s_axil_arready = !s.rvalid;
    assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
    assign rd_fire = s_axil_arvalid && s_axil_arready;
    assign wr_addr = align_addr(s.awaddr);
    assign rd_addr = align_addr(s_axil_araddr);

    // Next state: bus slave, registers and sticky status
    always_comb begin
        next_s = s;
        if (s_axil_awvalid && s_axil_awready) begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_axil_wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axil_wdata;
            next_s.wstrb = s_axil_wstrb;
        end
        if (s.bvalid && s_axil_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && s_axil_rready) begin
            next_s.rvalid = 1'b0;
        end
        // Write once both halves are in; read-only words ignore data
        if (wr_fire) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = is_mapped(wr_addr) ? `GPINT_RESP_OKAY : `GPINT_RESP_SLVERR;
            case (wr_addr)
                `GPINT_OFF_OUTPUT: next_s.out = merge(s.out, s.wdata, s.wstrb); // [RULE9]
                `GPINT_OFF_OE: next_s.oe = merge(s.oe, s.wdata, s.wstrb); // [RULE5] [RULE7]
                `GPINT_OFF_RISE_EN: next_s.rise_en = merge(s.rise_en, s.wdata, s.wstrb);
                `GPINT_OFF_FALL_EN: next_s.fall_en = merge(s.fall_en, s.wdata, s.wstrb);
                `GPINT_OFF_HIGH_EN: next_s.high_en = merge(s.high_en, s.wdata, s.wstrb);
                `GPINT_OFF_LOW_EN: next_s.low_en = merge(s.low_en, s.wdata, s.wstrb);
                `GPINT_OFF_MASK: next_s.mask = merge(s.mask, s.wdata, s.wstrb);
                default: ;
            endcase
        end
        // Read captures the word; a status read clears it
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_word(rd_addr, s, level); // [RULE7] [RULE8] [RULE9]
            next_s.rresp = is_mapped(rd_addr) ? `GPINT_RESP_OKAY : `GPINT_RESP_SLVERR;
            if (rd_addr == `GPINT_OFF_STATUS) begin
                next_s.status = `GPINT_RST_ZERO;
            end
        end
        // Set after clear, so a cause in the clearing cycle survives
        next_s.status = next_s.status | hits; // [RULE1] [RULE2] [RULE3] [RULE4]
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.mask <= `GPINT_RST_MASK;
        end else begin
            s <= next_s;
        end
    end

    // Outputs from flops; level causes re-set status each cycle, keeping irq high
    assign s_axil_bvalid = s.bvalid;
    assign s_axil_bresp = s.bresp;
    assign s_axil_rvalid = s.rvalid;
    assign s_axil_rdata = s.rdata;
    assign s_axil_rresp = s.rresp;
    assign pin_out = s.out; // [RULE9]
    assign pin_oe = s.oe; // [RULE5]
    assign irq = |(s.status & s.mask);

    // Checks on the port's own behaviour
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    rise_edge_sets_a: assert property ( // [RULE1]
        1'b1 |=> ((s.status & $past(rise_hit)) == $past(rise_hit)))
        else $error("rising edge did not set status");

    fall_edge_sets_a: assert property ( // [RULE2]
        (fall_hit != '0) |=> ((s.status & $past(fall_hit)) == $past(fall_hit)))
        else $error("falling edge did not set status");

    high_level_holds_a: assert property ( // [RULE3]
        ((high_hit & next_s.mask) != '0)
        |=> (irq && ((s.status & $past(high_hit)) == $past(high_hit))))
        else $error("high level interrupt dropped");

    low_level_holds_a: assert property ( // [RULE4]
        ((low_hit & next_s.mask) != '0)
        |=> (irq && ((s.status & $past(low_hit)) == $past(low_hit))))
        else $error("low level interrupt dropped");

    oe_write_drives_a: assert property ( // [RULE5]
        (wr_fire && wr_addr == `GPINT_OFF_OE && s.wstrb == 4'hF)
        |=> (pin_oe == $past(s.wdata)))
        else $error("output enable not taken from write");

    status_cause_only_a: assert property ( // [RULE6]
        1'b1 |=> ((s.status & ~$past(s.status)) & ~$past(hits)) == '0)
        else $error("status bit set without a cause on its pin");

    oe_readback_a: assert property ( // [RULE7]
        (rd_fire && rd_addr == `GPINT_OFF_OE) |=> s.rvalid && (s.rdata == $past(pin_oe)))
        else $error("output enable read back wrong");

    input_readback_a: assert property ( // [RULE8]
        (rd_fire && rd_addr == `GPINT_OFF_INPUT) |=> s.rvalid && (s.rdata == $past(level)))
        else $error("input read does not match sampled pins");

    out_readback_a: assert property ( // [RULE9]
        (rd_fire && rd_addr == `GPINT_OFF_OUTPUT) |=> (s.rdata == $past(pin_out)))
        else $error("output value read back wrong");

    write_answer_a: assert property (
        (s.aw_held && s.w_held && !s.bvalid) |=> s.bvalid)
        else $error("write response not raised one cycle after both halves");

    status_read_clear_a: assert property (
        (rd_fire && rd_addr == `GPINT_OFF_STATUS && hits == '0) |=> (s.status == '0))
        else $error("status read did not clear");

    // Answers stand until the master takes them
    bvalid_holds_a: assert property (
        (s.bvalid && !s_axil_bready) |=> (s.bvalid && $stable(s.bresp)))
        else $error("write response dropped before it was taken");

    rvalid_holds_a: assert property (
        (s.rvalid && !s_axil_rready) |=> (s.rvalid && $stable(s.rdata) && $stable(s.rresp)))
        else $error("read data changed before it was taken");

    read_answer_a: assert property (
        rd_fire |=> s.rvalid)
        else $error("read data not raised one cycle after the address");

    write_ok_resp_a: assert property (
        (wr_fire && is_mapped(wr_addr)) |=> (s.bresp == `GPINT_RESP_OKAY))
        else $error("mapped write not answered okay");

    write_err_resp_a: assert property (
        (wr_fire && !is_mapped(wr_addr)) |=> (s.bresp == `GPINT_RESP_SLVERR))
        else $error("unmapped write not answered with an error");

    read_ok_resp_a: assert property (
        (rd_fire && is_mapped(rd_addr)) |=> (s.rresp == `GPINT_RESP_OKAY))
        else $error("mapped read not answered okay");

    read_err_resp_a: assert property (
        (rd_fire && !is_mapped(rd_addr))
        |=> (s.rresp == `GPINT_RESP_SLVERR && s.rdata == `GPINT_RST_ZERO))
        else $error("unmapped read not answered with an error and zero");

    // Pin drive moves only on a write to its own word
    oe_stable_a: assert property ( // [RULE5]
        !(wr_fire && wr_addr == `GPINT_OFF_OE) |=> $stable(pin_oe))
        else $error("output enable changed without a write");

    out_stable_a: assert property ( // [RULE9]
        !(wr_fire && wr_addr == `GPINT_OFF_OUTPUT) |=> $stable(pin_out))
        else $error("output value changed without a write");

    lane_untouched_a: assert property ( // [RULE6]
        (wr_fire && wr_addr == `GPINT_OFF_OUTPUT && !s.wstrb[3])
        |=> (pin_out[31:24] == $past(pin_out[31:24])))
        else $error("unselected byte lane of output value changed");

    lane_written_a: assert property ( // [RULE6]
        (wr_fire && wr_addr == `GPINT_OFF_OUTPUT && s.wstrb[0])
        |=> (pin_out[7:0] == $past(s.wdata[7:0])))
        else $error("selected byte lane of output value not written");

    // Only a status read may drop a latched cause
    status_sticky_a: assert property ( // [RULE1] [RULE2]
        !(rd_fire && rd_addr == `GPINT_OFF_STATUS)
        |=> ((s.status & $past(s.status)) == $past(s.status)))
        else $error("status bit lost without a status read");

    mask_write_a: assert property (
        (wr_fire && wr_addr == `GPINT_OFF_MASK && s.wstrb == 4'hF)
        |=> (s.mask == $past(s.wdata)))
        else $error("mask not taken from write");

    rise_en_write_a: assert property ( // [RULE1]
        (wr_fire && wr_addr == `GPINT_OFF_RISE_EN && s.wstrb == 4'hF)
        |=> (s.rise_en == $past(s.wdata)))
        else $error("rising edge enable not taken from write");

    fall_en_write_a: assert property ( // [RULE2]
        (wr_fire && wr_addr == `GPINT_OFF_FALL_EN && s.wstrb == 4'hF)
        |=> (s.fall_en == $past(s.wdata)))
        else $error("falling edge enable not taken from write");

    high_en_write_a: assert property ( // [RULE3]
        (wr_fire && wr_addr == `GPINT_OFF_HIGH_EN && s.wstrb == 4'hF)
        |=> (s.high_en == $past(s.wdata)))
        else $error("high level enable not taken from write");

    low_en_write_a: assert property ( // [RULE4]
        (wr_fire && wr_addr == `GPINT_OFF_LOW_EN && s.wstrb == 4'hF)
        |=> (s.low_en == $past(s.wdata)))
        else $error("low level enable not taken from write");
endmodule

// ==== verif/gpint_pins.sv ====
// Pin-side model: wire level from the port's drive and the outside world
`timescale 1ns/10ps
module gpint_pins (
    // From the port
    input wire gpint_pkg::gpint_word_t pin_out,
    input wire gpint_pkg::gpint_word_t pin_oe,
    // Level the outside world puts on undriven pins
    input wire gpint_pkg::gpint_word_t ext_level,
    // Back to the port
    output gpint_pkg::gpint_word_t pin_in
);
    import gpint_pkg::*;
    // Driven pins follow the port, undriven ones the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ==== verif/gpint_top_bench.sv ====
// Self-checking bench for the pin port with interrupts
`timescale 1ns/10ps
`include "gpint_consts.svh"
module gpint_top_bench;
    import gpint_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    gpint_addr_t awaddr, araddr;
    gpint_strb_t wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    gpint_word_t pin_in, pin_out, pin_oe, ext;
    int bad_count, check_count, cycles;

    gpint_top gpint_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_awaddr(awaddr),
        .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_wdata(wdata),
        .s_axil_wstrb(wstrb), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_bresp(bresp), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_araddr(araddr), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
    gpint_pins gpint_pins_inst (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_in(pin_in));

    // Free-running 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task end_sim;
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask

    // Hang guard, generous against the fewer than 150 cycles needed
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim;
        end
    end

    // One write; each channel released at the edge that takes it
    task wr(input gpint_addr_t a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task rd(input gpint_addr_t a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task rdc(input string nm, input gpint_addr_t a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", {30'h0, `GPINT_RESP_OKAY}, {30'h0, r});
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task t_reset;
        rdc("output", `GPINT_OFF_OUTPUT, 32'h00000000);
        rdc("oe", `GPINT_OFF_OE, 32'h00000000);
        rdc("mask", `GPINT_OFF_MASK, 32'hFFFFFFFF);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    // Mixed drive: driven pins read back the port, others the outside level
    task t_drive;
        logic [1:0] r;
        wr(`GPINT_OFF_OUTPUT, 32'h12345678, r);
        wr(`GPINT_OFF_OE, 32'hFF00FF00, r);
        chk("pin_out", 32'h12345678, pin_out);
        chk("pin_oe", 32'hFF00FF00, pin_oe);
        rdc("output", `GPINT_OFF_OUTPUT, 32'h12345678);
        rdc("oe", `GPINT_OFF_OE, 32'hFF00FF00);
        wait_cyc(4);
        rdc("input", `GPINT_OFF_INPUT, 32'h12005600 | (32'h00FF00FF & ext));
    endtask

    // Edges on undriven pins 3 and 5; a wrong-direction edge first
    task t_edge;
        logic [1:0] r;
        wr(`GPINT_OFF_RISE_EN, 32'h00000008, r);
        wr(`GPINT_OFF_FALL_EN, 32'h00000020, r);
        ext[3] <= 1'b0;
        wait_cyc(6);
        rdc("status", `GPINT_OFF_STATUS, 32'h00000000);
        ext[3] <= 1'b1;
        ext[5] <= 1'b0;
        wait_cyc(6);
        chk("irq", 32'h1, {31'h0, irq});
        rdc("status", `GPINT_OFF_STATUS, 32'h00000028);
        rdc("status", `GPINT_OFF_STATUS, 32'h00000000);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`GPINT_OFF_RISE_EN, 32'h00000000, r);
        wr(`GPINT_OFF_FALL_EN, 32'h00000000, r);
    endtask

    // Level causes on pin 1 (high) and pin 16 (low) outlive a read
    task t_level;
        logic [1:0] r;
        wr(`GPINT_OFF_HIGH_EN, 32'h00000002, r);
        wr(`GPINT_OFF_LOW_EN, 32'h00010000, r);
        wait_cyc(5);
        rdc("status", `GPINT_OFF_STATUS, 32'h00010002);
        rdc("status", `GPINT_OFF_STATUS, 32'h00010002);
        chk("irq", 32'h1, {31'h0, irq});
        wr(`GPINT_OFF_MASK, 32'h00000000, r);
        chk("irq", 32'h0, {31'h0, irq});
        wr(`GPINT_OFF_MASK, 32'hFFFFFFFF, r);
        ext[1] <= 1'b0;
        ext[16] <= 1'b1;
        wait_cyc(6);
        rdc("status", `GPINT_OFF_STATUS, 32'h00010002);
        rdc("status", `GPINT_OFF_STATUS, 32'h00000000);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    // Unmapped place answers an error; read-only input ignores writes
    task t_bus;
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h40, 32'hFFFFFFFF, r);
        chk("bresp", {30'h0, `GPINT_RESP_SLVERR}, {30'h0, r});
        rd(8'h40, d, r);
        chk("rresp", {30'h0, `GPINT_RESP_SLVERR}, {30'h0, r});
        chk("rdata", 32'h00000000, d);
        wr(`GPINT_OFF_INPUT, 32'h00000000, r);
        chk("bresp", {30'h0, `GPINT_RESP_OKAY}, {30'h0, r});
        rdc("oe", `GPINT_OFF_OE, 32'hFF00FF00);
        // Lane 0 only; the other pins keep their output value
        wstrb <= 4'h1;
        wr(`GPINT_OFF_OUTPUT, 32'hFFFFFFFF, r);
        wstrb <= 4'hF;
        rdc("output", `GPINT_OFF_OUTPUT, 32'h123456FF);
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        ext = 32'h0000FFFF;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_drive;
        t_edge;
        t_level;
        t_bus;
        end_sim;
    end
endmodule
